// [design/slb_pkg.sv]
// Constants and field layout of the serial lane loopback/BERT control.
// Assumes a 40 MHz register clock and four lanes per port.
package slb_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_LANES = 4;
	localparam int CODE_W = 10;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PORT_W = 4;

	// ==========================================================
	// Register offsets (byte addresses) and indices
	localparam logic [ADDR_W-1:0] ADDR_LANE_CFG0 = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PORT_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_PAT_CTRL = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_FIX_PAT0 = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h28;
	localparam logic [3:0] IDX_CFG0 = 4'h0;
	localparam logic [3:0] IDX_PORT = 4'h4;
	localparam logic [3:0] IDX_PAT = 4'h5;
	localparam logic [3:0] IDX_FIX0 = 4'h6;
	localparam logic [3:0] IDX_STATUS = 4'hA;
	localparam logic [3:0] IDX_NONE = 4'hF;

	// ==========================================================
	// Lane configuration fields
	localparam int CFG_W = 12;
	localparam int CFG_DRV_LSB = 0;
	localparam int CFG_TRIM_LSB = 2;
	localparam int CFG_EMPH_LSB = 6;
	localparam int CFG_ALB_BIT = 10;
	localparam int CFG_FRMDIS_BIT = 11;
	localparam logic [CFG_W-1:0] CFG_RST = 12'h021;

	// Port control fields
	localparam int PORT_CTRL_W = 3;
	localparam int PORT_DLB_BIT = 0;
	localparam int PORT_RST_N_BIT = 1;
	localparam int PORT_LLB_BIT = 2;
	localparam logic [PORT_CTRL_W-1:0] PORT_CTRL_RST = 3'h0;

	// Pattern control: one byte per lane, source in the low three bits
	localparam int PAT_FIELD_W = 8;
	localparam int PAT_SEL_W = 3;
	localparam logic [PAT_SEL_W-1:0] PAT_NORMAL = 3'h0;
	localparam logic [PAT_SEL_W-1:0] PAT_PRBS = 3'h1;
	localparam logic [PAT_SEL_W-1:0] PAT_FIXED = 3'h4;

	// Fixed pattern: two code groups per lane
	localparam int FIX_PAT_W = 20;
	localparam logic [FIX_PAT_W-1:0] FIX_PAT_RST = 20'h00000;

	// Status fields
	localparam int STAT_ALB_LSB = 0;
	localparam int STAT_BERT_LSB = 4;
	localparam int STAT_SETTLED_BIT = 8;
	localparam int STAT_DLB_BIT = 9;

	// ==========================================================
	// Drive arithmetic, levels in units of 10 uA
	localparam int LVL_W = 12;
	localparam logic [4:0] NOM_MA_LOW = 5'h0A;
	localparam logic [4:0] NOM_MA_MID = 5'h14;
	localparam logic [4:0] NOM_MA_HIGH = 5'h1C;
	localparam logic [7:0] PCT_BASE = 8'h3C;
	localparam logic [7:0] PCT_STEP = 8'h05;
	localparam logic [7:0] EMPH_STEP_PCT = 8'h04;
	localparam logic [7:0] PCT_FULL = 8'h64;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int RST_WAIT_NS = 500;
	localparam int RST_WAIT_CYC =
		(RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Pattern generator and bus answers
	localparam logic [6:0] PRBS_SEED = 7'h7F;
	localparam int PRBS_TAP_A = 6;
	localparam int PRBS_TAP_B = 5;
	localparam int PRBS_BITS = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [design/slb_drive.sv]
// Per-lane transmit current arithmetic: nominal, trimmed and emphasised level.
// Assumes settings come from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module slb_drive (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [1:0] i_sel,
	input wire logic [3:0] i_trim,
	input wire logic [3:0] i_emph,
	output logic [slb_pkg::LVL_W-1:0] o_level,
	output logic [slb_pkg::LVL_W-1:0] o_emph_level
);
	import slb_pkg::*;

	logic [4:0] nom_ma;
	logic [7:0] pct;
	logic [LVL_W-1:0] level;
	logic [17:0] drop;

	// ==========================================================
	// Level calculation
	always_comb begin
		// RQ1 nominal current select
		unique case (i_sel)
			2'b00: nom_ma = NOM_MA_LOW;
			2'b01: nom_ma = NOM_MA_MID;
			default: nom_ma = NOM_MA_HIGH;
		endcase
		// RQ2 trim in five percent steps
		pct = 8'(PCT_BASE + PCT_STEP * {4'h0, i_trim});
		level = LVL_W'({8'h00, nom_ma} * {5'h00, pct});
		// RQ3 drop after first bit
		drop = (18'(level) * 18'(i_emph) * 18'(EMPH_STEP_PCT))
			/ 18'(PCT_FULL);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_level <= 12'h000;
			o_emph_level <= 12'h000;
		end else begin
			o_level <= level;
			o_emph_level <= level - LVL_W'(drop);
		end
	end

	a_drive_max: assert property (@(posedge i_clk) disable iff (i_reset)
		($past(i_sel) == 2'b10 && $past(i_trim) == 4'hF)
		|-> o_level == 12'hEC4) // RQ2
		else $error("drive level not 135 percent of 28 mA");
	a_drive_min: assert property (@(posedge i_clk) disable iff (i_reset)
		($past(i_sel) == 2'b00 && $past(i_trim) == 4'h0
		&& $past(i_emph) == 4'h0)
		|-> (o_level == 12'h258 && o_emph_level == 12'h258)) // RQ1
		else $error("drive level not 60 percent of 10 mA");

endmodule
`default_nettype wire

// [design/slb_lane.sv]
// One serial lane: pattern generation, loopback muxes and framer control.
// Assumes rx line data already synchronised to the clock.
`timescale 1ns/1ps
`default_nettype none
module slb_lane (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [slb_pkg::PAT_SEL_W-1:0] i_pat_sel,
	input wire logic [slb_pkg::FIX_PAT_W-1:0] i_fix_pat,
	input wire logic i_alb,
	input wire logic i_dlb,
	input wire logic i_framer_dis,
	input wire logic i_lane_rst_n,
	input wire logic [slb_pkg::CODE_W-1:0] i_tx_code,
	input wire logic [slb_pkg::CODE_W-1:0] i_rx_line,
	output logic [slb_pkg::CODE_W-1:0] o_tx_line,
	output logic [slb_pkg::CODE_W-1:0] o_rx_code,
	output logic o_rx_valid,
	output logic o_tx_ready,
	output logic o_framer_en
);
	import slb_pkg::*;

	logic [6:0] lfsr_q;
	logic [6:0] lfsr_d;
	logic phase_q;
	logic [CODE_W-1:0] prbs_word;
	logic [CODE_W-1:0] fix_word;
	logic bert;

	function automatic logic [6:0] prbs_step(input logic [6:0] s);
		prbs_step = {s[5:0], s[PRBS_TAP_A] ^ s[PRBS_TAP_B]};
	endfunction

	// ==========================================================
	// Pattern sources
	always_comb begin
		lfsr_d = lfsr_q;
		prbs_word = '0;
		// RQ19 each bit paired with its complement
		for (int i = 0; i < PRBS_BITS; i++) begin
			prbs_word[2*i+1] = lfsr_d[6];
			prbs_word[2*i] = ~lfsr_d[6];
			lfsr_d = prbs_step(lfsr_d);
		end
		// RQ20 alternate the two code groups
		fix_word = phase_q ? i_fix_pat[FIX_PAT_W-1:CODE_W]
			: i_fix_pat[CODE_W-1:0];
		bert = (i_pat_sel != PAT_NORMAL);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || i_pat_sel != PAT_PRBS) begin
			lfsr_q <= PRBS_SEED;
		end else begin
			lfsr_q <= lfsr_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || i_pat_sel != PAT_FIXED) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
		end
	end

	// ==========================================================
	// Transmit side
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_lane_rst_n) begin
			o_tx_line <= 10'h000;
		end else begin
			// RQ16 test pattern replaces traffic
			unique case (i_pat_sel)
				PAT_PRBS: o_tx_line <= prbs_word;
				PAT_FIXED: o_tx_line <= fix_word;
				default: o_tx_line <= i_tx_code;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_tx_ready <= 1'b0;
			o_framer_en <= 1'b0;
		end else begin
			// RQ16 traffic held off during test
			o_tx_ready <= (i_lane_rst_n || i_dlb) && !bert;
			// RQ13 framer realignment off
			o_framer_en <= !i_framer_dis;
		end
	end

	// ==========================================================
	// Receive side
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rx_code <= 10'h000;
			o_rx_valid <= 1'b0;
		end else begin
			// RQ10 RQ12 port loop before encoding
			if (i_dlb) begin
				o_rx_code <= i_tx_code;
			// RQ6 RQ9 loop at line edge
			end else if (i_alb) begin
				o_rx_code <= o_tx_line;
			end else begin
				o_rx_code <= i_rx_line;
			end
			// RQ11 no training needed in port loop
			o_rx_valid <= i_dlb || (i_lane_rst_n && !bert);
		end
	end

	a_alb_path: assert property (@(posedge i_clk) disable iff (i_reset)
		($past(i_alb) && !$past(i_dlb))
		|-> o_rx_code == $past(o_tx_line)) // RQ6
		else $error("analog loopback did not return tx line");
	a_framer_ctl: assert property (@(posedge i_clk) disable iff (i_reset)
		$past(i_framer_dis) |-> !o_framer_en) // RQ13
		else $error("framer still enabled while disabled");

endmodule
`default_nettype wire

// [design/slb_top.sv]
// Serial port loopback, drive tuning and BERT control with AXI4-Lite registers.
// Assumes one 40 MHz clock; line inputs arrive from another domain.
//
// Functional notes
// RQ1 - drive select picks 10, 20, 28 mA
// RQ2 - trim sets 60 to 135 percent, 5% steps
// RQ3 - pre-emphasis ratio sets drop after first bit
// RQ4 - every lane has its own drive settings
// RQ5 - software keeps drive within link limits
// RQ6 - per-lane analog loopback ignores external data
// RQ7 - analog loopback changes only during SerDes reset
// RQ8 - software: reset, configure, wait 500 ns, release
// RQ9 - analog loop sits at line edge
// RQ10 - port digital loopback before line encoding
// RQ11 - no test patterns in digital loopback
// RQ12 - digital loopback discards external link data
// RQ13 - framer disable stops codeword realignment
// RQ14 - software disables framer before BERT
// RQ15 - logical loopback routes all to ingress
// RQ16 - per-lane BERT stops normal traffic
// RQ17 - pattern control: normal, PRBS or fixed
// RQ18 - partner checks PRBS, fixed or loops
// RQ19 - PRBS sequence is DC balanced
// RQ20 - code 100 sends 20-bit fixed pattern
// RQ21 - reset bit low holds four lanes
`timescale 1ns/1ps
`default_nettype none
module slb_top (
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [slb_pkg::ADDR_W-1:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [slb_pkg::DATA_W-1:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [slb_pkg::ADDR_W-1:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [slb_pkg::DATA_W-1:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic [39:0] I_TX_CODE,
	output logic [3:0] O_TX_READY,
	output logic [39:0] O_TX_LINE,
	input wire logic [39:0] I_RX_LINE,
	output logic [39:0] O_RX_CODE,
	output logic [3:0] O_RX_VALID,
	output logic [3:0] O_FRAMER_EN,
	output logic [3:0] O_LANE_RST_N,
	output logic [3:0] O_ANALOG_LB,
	output logic [47:0] O_DRIVE_LVL,
	output logic [47:0] O_EMPH_LVL,
	input wire logic I_ROUTE_VALID,
	input wire logic [slb_pkg::PORT_W-1:0] I_ROUTE_DEST_PORT,
	input wire logic [slb_pkg::PORT_W-1:0] I_INGRESS_PORT,
	output logic O_ROUTE_VALID,
	output logic [slb_pkg::PORT_W-1:0] O_ROUTE_PORT
);
	import slb_pkg::*;

	logic [CFG_W-1:0] lane_cfg_q [NUM_LANES];
	logic [PORT_CTRL_W-1:0] port_ctrl_q;
	logic [PAT_SEL_W-1:0] pat_sel_q [NUM_LANES];
	logic [PAT_SEL_W-1:0] pat_eff [NUM_LANES];
	logic [FIX_PAT_W-1:0] fix_pat_q [NUM_LANES];
	logic [NUM_LANES-1:0] bert_act;
	logic [4:0] rst_cnt_q;
	logic settled_q;
	logic [39:0] rx_meta_q;
	logic [39:0] rx_sync_q;
	logic dlb;
	logic rst_n;

	logic aw_take, w_take, aw_have_q, w_have_q, aw_have_d, w_have_d;
	logic do_write, bvalid_d, ar_take, rvalid_d;
	logic [ADDR_W-1:0] awaddr_q, wr_addr;
	logic [DATA_W-1:0] wdata_q, wr_data, wr_new;
	logic [3:0] wstrb_q, wr_strb, wr_idx, rd_idx;

	// ==========================================================
	// Register decode helpers
	function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
		if (a[1:0] != 2'b00 || a > ADDR_STATUS) begin
			reg_index = IDX_NONE;
		end else begin
			reg_index = a[5:2];
		end
	endfunction

	function automatic logic [DATA_W-1:0] reg_read(input logic [3:0] idx);
		reg_read = '0;
		if (idx < IDX_PORT) begin
			reg_read[CFG_W-1:0] = lane_cfg_q[idx[1:0]];
		end else if (idx == IDX_PORT) begin
			reg_read[PORT_CTRL_W-1:0] = port_ctrl_q;
		end else if (idx == IDX_PAT) begin
			for (int n = 0; n < NUM_LANES; n++) begin
				reg_read[n*PAT_FIELD_W +: PAT_SEL_W] = pat_sel_q[n];
			end
		end else if (idx < IDX_STATUS) begin
			reg_read[FIX_PAT_W-1:0] = fix_pat_q[2'(idx - IDX_FIX0)];
		end else if (idx == IDX_STATUS) begin
			reg_read[STAT_ALB_LSB +: NUM_LANES] = O_ANALOG_LB;
			reg_read[STAT_BERT_LSB +: NUM_LANES] = bert_act;
			reg_read[STAT_SETTLED_BIT] = settled_q;
			reg_read[STAT_DLB_BIT] = dlb;
		end
	endfunction

	// ==========================================================
	// AXI4-Lite write channel
	always_comb begin
		aw_take = I_AWVALID && O_AWREADY;
		w_take = I_WVALID && O_WREADY;
		aw_have_d = aw_have_q || aw_take;
		w_have_d = w_have_q || w_take;
		wr_addr = aw_have_q ? awaddr_q : I_AWADDR;
		wr_data = w_have_q ? wdata_q : I_WDATA;
		wr_strb = w_have_q ? wstrb_q : I_WSTRB;
		do_write = aw_have_d && w_have_d && !O_BVALID;
		bvalid_d = do_write || (O_BVALID && !I_BREADY);
		wr_idx = reg_index(wr_addr);
		wr_new = reg_read(wr_idx);
		for (int b = 0; b < 4; b++) begin
			if (wr_strb[b]) begin
				wr_new[b*8 +: 8] = wr_data[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d && !do_write;
			w_have_q <= w_have_d && !do_write;
			if (aw_take) begin
				awaddr_q <= I_AWADDR;
			end
			if (w_take) begin
				wdata_q <= I_WDATA;
				wstrb_q <= I_WSTRB;
			end
			O_AWREADY <= !bvalid_d && !(aw_have_d && !do_write);
			O_WREADY <= !bvalid_d && !(w_have_d && !do_write);
			O_BVALID <= bvalid_d;
			if (do_write) begin
				O_BRESP <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_comb begin
		ar_take = I_ARVALID && O_ARREADY;
		rvalid_d = ar_take || (O_RVALID && !I_RREADY);
		rd_idx = reg_index(I_ARADDR);
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h00000000;
			O_RRESP <= RESP_OKAY;
		end else begin
			O_ARREADY <= !rvalid_d;
			O_RVALID <= rvalid_d;
			if (ar_take) begin
				O_RDATA <= reg_read(rd_idx);
				O_RRESP <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge I_REF_CLK) begin
		for (int n = 0; n < NUM_LANES; n++) begin
			if (I_RESET) begin
				lane_cfg_q[n] <= CFG_RST;
				pat_sel_q[n] <= PAT_NORMAL;
				fix_pat_q[n] <= FIX_PAT_RST;
			end else if (do_write) begin
				// RQ4 separate settings per lane
				if (wr_idx == IDX_CFG0 + 4'(n)) begin
					lane_cfg_q[n] <= wr_new[CFG_W-1:0];
				end
				// RQ17 per-lane pattern source
				if (wr_idx == IDX_PAT) begin
					pat_sel_q[n] <= wr_new[n*PAT_FIELD_W +: PAT_SEL_W];
				end
				if (wr_idx == IDX_FIX0 + 4'(n)) begin
					fix_pat_q[n] <= wr_new[FIX_PAT_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			port_ctrl_q <= PORT_CTRL_RST;
		end else if (do_write && wr_idx == IDX_PORT) begin
			port_ctrl_q <= wr_new[PORT_CTRL_W-1:0];
		end
	end

	always_comb begin
		dlb = port_ctrl_q[PORT_DLB_BIT];
		rst_n = port_ctrl_q[PORT_RST_N_BIT];
		for (int n = 0; n < NUM_LANES; n++) begin
			// RQ11 patterns blocked in digital loopback
			if (dlb || !(pat_sel_q[n] == PAT_PRBS
				|| pat_sel_q[n] == PAT_FIXED)) begin
				pat_eff[n] = PAT_NORMAL;
			end else begin
				pat_eff[n] = pat_sel_q[n];
			end
			bert_act[n] = (pat_eff[n] != PAT_NORMAL);
		end
	end

	// ==========================================================
	// SerDes reset and analog loopback gating
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_LANE_RST_N <= 4'h0;
			O_ANALOG_LB <= 4'h0;
			rst_cnt_q <= 5'h00;
			settled_q <= 1'b0;
		end else begin
			// RQ21 low holds all lanes
			O_LANE_RST_N <= {NUM_LANES{rst_n}};
			// RQ7 loopback taken only under reset
			if (!rst_n) begin
				for (int n = 0; n < NUM_LANES; n++) begin
					O_ANALOG_LB[n] <= lane_cfg_q[n][CFG_ALB_BIT];
				end
			end
			if (rst_n) begin
				rst_cnt_q <= 5'h00;
				settled_q <= 1'b0;
			end else if (32'(rst_cnt_q) < RST_WAIT_CYC) begin
				rst_cnt_q <= rst_cnt_q + 5'h01;
			end else begin
				settled_q <= 1'b1;
			end
		end
	end

	// Line inputs come from the SerDes domain
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			rx_meta_q <= 40'h0000000000;
			rx_sync_q <= 40'h0000000000;
		end else begin
			rx_meta_q <= I_RX_LINE;
			rx_sync_q <= rx_meta_q;
		end
	end

	// ==========================================================
	// Lanes
	for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
		slb_lane u_lane (
			.i_clk(I_REF_CLK),
			.i_reset(I_RESET),
			.i_pat_sel(pat_eff[g]),
			.i_fix_pat(fix_pat_q[g]),
			.i_alb(O_ANALOG_LB[g]),
			.i_dlb(dlb),
			.i_framer_dis(lane_cfg_q[g][CFG_FRMDIS_BIT]),
			.i_lane_rst_n(rst_n),
			.i_tx_code(I_TX_CODE[g*CODE_W +: CODE_W]),
			.i_rx_line(rx_sync_q[g*CODE_W +: CODE_W]),
			.o_tx_line(O_TX_LINE[g*CODE_W +: CODE_W]),
			.o_rx_code(O_RX_CODE[g*CODE_W +: CODE_W]),
			.o_rx_valid(O_RX_VALID[g]),
			.o_tx_ready(O_TX_READY[g]),
			.o_framer_en(O_FRAMER_EN[g])
		);
		slb_drive u_drive (
			.i_clk(I_REF_CLK),
			.i_reset(I_RESET),
			.i_sel(lane_cfg_q[g][CFG_DRV_LSB +: 2]),
			.i_trim(lane_cfg_q[g][CFG_TRIM_LSB +: 4]),
			.i_emph(lane_cfg_q[g][CFG_EMPH_LSB +: 4]),
			.o_level(O_DRIVE_LVL[g*LVL_W +: LVL_W]),
			.o_emph_level(O_EMPH_LVL[g*LVL_W +: LVL_W])
		);
	end

	// ==========================================================
	// Logical line loopback on the routing lookup
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_ROUTE_VALID <= 1'b0;
			O_ROUTE_PORT <= 4'h0;
		end else begin
			O_ROUTE_VALID <= I_ROUTE_VALID;
			// RQ15 every destination to ingress
			O_ROUTE_PORT <= port_ctrl_q[PORT_LLB_BIT] ? I_INGRESS_PORT
				: I_ROUTE_DEST_PORT;
		end
	end

	// ==========================================================
	// Checks
	a_alb_frozen: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		($past(rst_n) && rst_n) |=> $stable(O_ANALOG_LB)) // RQ7
		else $error("analog loopback changed outside SerDes reset");
	a_dlb_feed: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		dlb |=> O_RX_CODE == $past(I_TX_CODE)) // RQ12
		else $error("digital loopback did not return tx codes");
	a_dlb_no_bert: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		dlb |=> O_TX_READY == 4'hF) // RQ11
		else $error("test pattern active in digital loopback");
	a_bert_stops: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		bert_act[0] |=> !O_TX_READY[0] && !O_RX_VALID[0]) // RQ16
		else $error("lane 0 traffic not stopped during test");
	a_fixed_word: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(pat_eff[1] == PAT_FIXED && rst_n)[*2]
		|=> (O_TX_LINE[19:10] == fix_pat_q[1][9:0]
		|| O_TX_LINE[19:10] == fix_pat_q[1][19:10])) // RQ20
		else $error("lane 1 fixed pattern not transmitted");
	a_prbs_balance: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(pat_eff[0] == PAT_PRBS && rst_n)
		|=> $countones(O_TX_LINE[9:0]) == 5) // RQ19
		else $error("lane 0 PRBS word not DC balanced");
	a_lane_reset: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		!rst_n |=> O_LANE_RST_N == 4'h0 ##1 (O_TX_LINE == '0 || rst_n)) // RQ21
		else $error("lanes not held in reset");
	a_route_back: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		port_ctrl_q[PORT_LLB_BIT] |=> O_ROUTE_PORT == $past(I_INGRESS_PORT)) // RQ15
		else $error("logical loopback did not route to ingress");
	a_write_resp: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		do_write |=> O_BVALID && !O_AWREADY) // AXI4-Lite write response
		else $error("write response missing");

endmodule
`default_nettype wire

// [tb/slb_link_partner.sv]
// Link partner model standing on the four lanes.
// Assumes one code group per lane moves each clock.
`timescale 1ns/1ps
`default_nettype none
module slb_link_partner (
	input wire logic i_clk,
	input wire logic i_loop,
	input wire logic [39:0] i_line,
	output logic [39:0] o_line
);
	logic [39:0] junk_q = 40'h0;
	// ==========================================================
	// Traffic source
	// Changes every cycle so stale data never matches
	always_ff @(posedge i_clk) begin
		junk_q <= junk_q + 40'h1A5A5A5A5B;
	end
	assign o_line = i_loop ? i_line : junk_q;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the loopback, drive and BERT control block.
// Assumes the design files and the link partner model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import slb_pkg::*;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic rtv_in = 1, loop = 1, awr, wrd, bv, arr, rvo, rtv;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, rdo;
	logic [39:0] txc = 40'h0123456789, rxl, txl, rxc;
	logic [3:0] dst = 4'h5, ing = 4'h9, rp, trdy, rvl, fen, lrn, alb;
	logic [47:0] dl, el;
	logic [1:0] rsp, brsp, rrsp;
	logic [9:0] a, b;
	int mismatches = 0, cmp_count = 0, cyc = 0;
	always #12.5 clk = ~clk;
	// ==========================================================
	// Design and partner
	slb_top u_slb_top (.I_REF_CLK(clk), .I_RESET(rst),
		.I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
		.I_WVALID(wv), .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(4'hF),
		.O_BVALID(bv), .I_BREADY(bre), .O_BRESP(brsp),
		.I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
		.O_RVALID(rvo), .I_RREADY(rre), .O_RDATA(rdo), .O_RRESP(rrsp),
		.I_TX_CODE(txc), .O_TX_READY(trdy), .O_TX_LINE(txl),
		.I_RX_LINE(rxl), .O_RX_CODE(rxc), .O_RX_VALID(rvl),
		.O_FRAMER_EN(fen), .O_LANE_RST_N(lrn), .O_ANALOG_LB(alb),
		.O_DRIVE_LVL(dl), .O_EMPH_LVL(el), .I_ROUTE_VALID(rtv_in),
		.I_ROUTE_DEST_PORT(dst), .I_INGRESS_PORT(ing),
		.O_ROUTE_VALID(rtv), .O_ROUTE_PORT(rp));
	slb_link_partner u_slb_link_partner (.i_clk(clk), .i_loop(loop),
		.i_line(txl), .o_line(rxl));
	// ==========================================================
	// Bus and compare tasks
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bit done = 0;
		awv <= 1;
		wv <= 1;
		awa <= ad;
		wd <= d;
		bre <= 1;
		while (!done) begin
			@(posedge clk);
			if (awr === 1'b1)
				awv <= 0;
			if (wrd === 1'b1)
				wv <= 0;
			if (bv === 1'b1) begin
				rsp = brsp;
				done = 1;
			end
		end
	endtask
	task automatic rd(input logic [7:0] ad);
		bit done = 0;
		arv <= 1;
		ara <= ad;
		rre <= 1;
		while (!done) begin
			@(posedge clk);
			if (arr === 1'b1)
				arv <= 0;
			if (rvo === 1'b1) begin
				rdat = rdo;
				rsp = rrsp;
				done = 1;
			end
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rd(ADDR_LANE_CFG0 + 8'h0C);
		chk(rdat, CFG_RST);
		rd(8'h2C);
		chk({rsp, rdat}, {RESP_SLVERR, 32'h0});
		wr(8'h02, 32'hFFF);
		chk(rsp, RESP_SLVERR);
		chk(dl, 48'h7D07D07D07D0);
		chk(lrn, 4'h0);
		$display("test reset done");
	endtask
	task automatic t_drive();
		wr(ADDR_LANE_CFG0 + 8'h04, 32'h29E);
		wr(ADDR_LANE_CFG0 + 8'h08, 32'h03C);
		repeat (2) @(posedge clk);
		chk(dl, 48'h7D0546A647D0);
		chk(el, 48'h7D054663C7D0);
		$display("test drive done");
	endtask
	task automatic t_alb();
		wr(ADDR_PORT_CTRL, 32'h2);
		repeat (6) @(posedge clk);
		chk({lrn, rxc[9:0]}, {4'hF, 10'h389});
		wr(ADDR_LANE_CFG0, 32'h421);
		repeat (2) @(posedge clk);
		chk(alb, 4'h0);
		wr(ADDR_PORT_CTRL, 32'h0);
		wr(ADDR_LANE_CFG0, 32'h421);
		repeat (RST_WAIT_CYC) @(posedge clk);
		rd(ADDR_STATUS);
		chk({lrn, rdat[8]}, 5'h01);
		wr(ADDR_PORT_CTRL, 32'h2);
		loop <= 0;
		repeat (6) @(posedge clk);
		chk({alb, rxc[9:0]}, {4'h1, 10'h389});
		wr(ADDR_PORT_CTRL, 32'h0);
		wr(ADDR_LANE_CFG0, 32'h021);
		repeat (RST_WAIT_CYC) @(posedge clk);
		wr(ADDR_PORT_CTRL, 32'h2);
		$display("test analog loop done");
	endtask
	task automatic t_bert();
		wr(ADDR_LANE_CFG0 + 8'h04, 32'hA9E);
		wr(ADDR_LANE_CFG0 + 8'h08, 32'h83C);
		repeat (2) @(posedge clk);
		chk(fen, 4'h9);
		wr(ADDR_FIX_PAT0 + 8'h04, 32'hABCDE);
		wr(ADDR_PAT_CTRL, 32'h02010400);
		repeat (4) @(posedge clk);
		chk({trdy, txl[39:30]}, {4'h9, 10'h004});
		for (int i = 0; i < 3; i++) begin
			a = txl[19:10];
			chk($countones(txl[29:20]), 5);
			@(posedge clk);
			b = txl[19:10];
			chk({a, b} ^ {b, a}, 20'h2AF ^ 20'h0DE << 10 ^ 20'h2AF << 10
				^ 20'h0DE);
		end
		rd(ADDR_PAT_CTRL);
		chk(rdat, 32'h02010400);
		wr(ADDR_PAT_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		chk(trdy, 4'hF);
		$display("test bert done");
	endtask
	task automatic t_dlb();
		wr(ADDR_PAT_CTRL, 32'h1);
		wr(ADDR_PORT_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		chk({trdy, rvl, rxc}, {4'hF, 4'hF, txc});
		rd(ADDR_STATUS);
		chk(rdat[9], 1'b1);
		wr(ADDR_PAT_CTRL, 32'h0);
		wr(ADDR_PORT_CTRL, 32'h6);
		repeat (2) @(posedge clk);
		chk({rtv, rp}, 5'h19);
		wr(ADDR_PORT_CTRL, 32'h2);
		repeat (2) @(posedge clk);
		chk(rp, 4'h5);
		$display("test digital and logical loop done");
	endtask
	// ==========================================================
	// Sequence and timeout
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		t_reset();
		t_drive();
		t_alb();
		t_bert();
		t_dlb();
		tally_and_finish();
	end
endmodule
`default_nettype wire
